/* rtl/data_space_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module data_space_decoder
    import data_space_pkg::*;
#(
    parameter int unsigned NVM_WRITE_TIME = NVM_WRITE_CYCLES
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic                          req_write,
    input  wire data_space_pkg::access_mode_type req_mode,
    input  wire logic [15:0]                   req_addr,
    input  wire data_space_pkg::ptr_sel_type   req_ptr,
    input  wire logic [5:0]                    req_disp,
    input  wire logic [2:0]                    req_bit,
    input  wire logic [7:0]                    req_wdata,
    output logic                               resp_valid,
    output logic [7:0]                         resp_rdata,
    output logic                               resp_skip,
    input  wire logic [15:0]                   ptr_x_value,
    input  wire logic [15:0]                   ptr_y_value,
    input  wire logic [15:0]                   ptr_z_value,
    output logic                               ptr_we,
    output logic [4:0]                         ptr_low_index,
    output logic [15:0]                        ptr_wdata,
    output logic                               reg_sel,
    output logic                               reg_we,
    output logic [4:0]                         reg_addr,
    output logic [7:0]                         reg_wdata,
    input  wire logic [7:0]                    reg_rdata,
    output logic                               io_sel,
    output logic                               io_we,
    output logic [7:0]                         io_addr,
    output logic [7:0]                         io_wdata,
    output logic [7:0]                         io_wmask,
    input  wire logic [7:0]                    io_rdata,
    input  wire logic [13:0]                   pc_next,
    output logic [13:0]                        prog_addr,
    input  wire logic                          nvm_read_set,
    input  wire logic                          nvm_write_arm,
    input  wire logic                          nvm_write_strobe,
    input  wire logic [9:0]                    nvm_addr,
    input  wire logic [7:0]                    nvm_data_in,
    output logic [7:0]                         nvm_rdata,
    output logic                               nvm_busy,
    output logic                               cpu_stall,
    input  wire logic                          low_supply_detector
);
    import data_space_pkg::*;

    // ------------------------------------------------------------
    // address generation
    // ------------------------------------------------------------
    logic [15:0]     base;
    logic [15:0]     ea;
    logic [15:0]     io_offset_addr;
    logic            take;
    logic            is_bit_op;
    logic            bit_in_range;
    region_type      region;
    logic [2:0]      stall_cnt;
    logic [2:0]      arm_cnt;

    assign take = req_valid && req_ready;
    assign is_bit_op = req_mode inside {io_bit_set_op, io_bit_clear_op,
                                        io_bit_skip_if_set_op, io_bit_skip_if_clear_op};
    assign bit_in_range = req_addr[5:0] <= BIT_IO_LAST;
    // port and bit forms carry only six address bits, so extended io is unreachable
    assign io_offset_addr = {10'h000, req_addr[5:0]} + IO_BASE;

    always_comb begin
        unique case (req_ptr)
            ptr_x:   base = ptr_x_value;
            ptr_y:   base = ptr_y_value;
            default: base = ptr_z_value;
        endcase
    end

    always_comb begin
        unique case (req_mode)
            direct_op:        ea = req_addr;
            indirect_op:      ea = base;
            // the low pointer pair has no displacement form; its offset is dropped
            indirect_disp_op: ea = base + ((req_ptr == ptr_x) ? 16'h0000
                                           : {10'h000, req_disp & DISP_MAX});
            pre_dec_op:       ea = base - 16'h0001;
            post_inc_op:      ea = base;
            default:          ea = io_offset_addr;
        endcase
    end

    always_comb begin
        if (ea < IO_BASE) begin
            region = region_reg;
        end else if (ea < SRAM_BASE) begin
            region = region_io;
        end else if (ea < SRAM_END) begin
            region = region_sram;
        end else begin
            region = region_none;
        end
    end

    // ------------------------------------------------------------
    // sram
    // ------------------------------------------------------------
    logic [10:0] sram_addr;
    logic [7:0]  sram_q;
    logic        sram_we;

    assign sram_addr = 11'(ea - SRAM_BASE);
    assign sram_we   = take && req_write && region == region_sram && !is_bit_op;

    byte_memory #(
        .DEPTH      (SRAM_BYTES),
        .ADDR_WIDTH (11)
    ) sram_mem (
        .clk_sys (clk_sys),
        .we      (sram_we),
        .addr    (sram_addr),
        .wdata   (req_wdata),
        .rdata   (sram_q)
    );

    // ------------------------------------------------------------
    // target strobes, one cycle after the request is taken
    // ------------------------------------------------------------
    region_type      region_q;
    access_mode_type mode_q;
    logic [2:0]      bit_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            resp_valid <= 1'b0;
            reg_sel    <= 1'b0;
            reg_we     <= 1'b0;
            io_sel     <= 1'b0;
            io_we      <= 1'b0;
            region_q   <= region_none;
            mode_q     <= direct_op;
            bit_q      <= 3'd0;
            reg_addr   <= 5'd0;
            reg_wdata  <= 8'h00;
            io_addr    <= 8'h00;
            io_wdata   <= 8'h00;
            io_wmask   <= 8'h00;
        end else begin
            resp_valid <= take;
            region_q   <= region;
            mode_q     <= req_mode;
            bit_q      <= req_bit;
            reg_sel    <= take && region == region_reg && !is_bit_op;
            reg_we     <= take && region == region_reg && !is_bit_op && req_write;
            reg_addr   <= ea[4:0];
            // out-of-range bit ops neither read nor write
            io_sel     <= take && region == region_io && (!is_bit_op || bit_in_range);
            io_we      <= take && region == region_io &&
                          (is_bit_op ? (bit_in_range && req_mode inside
                                        {io_bit_set_op, io_bit_clear_op}) : req_write);
            io_addr    <= 8'(ea - IO_BASE);
            if (req_mode == io_bit_set_op || req_mode == io_bit_clear_op) begin
                // mask limits the write to one bit, so a write-one-to-clear flag
                // elsewhere in the register is untouched
                io_wmask <= 8'h01 << req_bit;
                io_wdata <= (req_mode == io_bit_set_op) ? (8'h01 << req_bit) : 8'h00;
            end else begin
                io_wmask <= FULL_MASK;
                io_wdata <= req_wdata;
            end
            reg_wdata  <= req_wdata;
        end
    end

    always_comb begin
        unique case (region_q)
            region_reg:  resp_rdata = reg_rdata;
            region_io:   resp_rdata = io_sel ? io_rdata : 8'h00;
            region_sram: resp_rdata = sram_q;
            default:     resp_rdata = 8'h00;
        endcase
    end

    // skip answer taken from the selected bit of the low io register
    always_comb begin
        resp_skip = 1'b0;
        if (resp_valid && io_sel) begin
            if (mode_q == io_bit_skip_if_set_op) begin
                resp_skip = io_rdata[bit_q];
            end else if (mode_q == io_bit_skip_if_clear_op) begin
                resp_skip = !io_rdata[bit_q];
            end
        end
    end

    // ------------------------------------------------------------
    // pointer write-back
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_we        <= 1'b0;
            ptr_low_index <= PTR_X_LOW;
            ptr_wdata     <= 16'h0000;
        end else begin
            ptr_we    <= take && (req_mode == pre_dec_op || req_mode == post_inc_op);
            ptr_wdata <= (req_mode == pre_dec_op) ? base - 16'h0001
                                                  : base + 16'h0001;
            unique case (req_ptr)
                ptr_x:   ptr_low_index <= PTR_X_LOW;
                ptr_y:   ptr_low_index <= PTR_Y_LOW;
                default: ptr_low_index <= PTR_Z_LOW;
            endcase
        end
    end

    // ------------------------------------------------------------
    // program address, held while the cpu is stalled
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prog_addr <= 14'h0000;
        end else if (!cpu_stall) begin
            prog_addr <= pc_next;
        end
    end

    // ------------------------------------------------------------
    // nonvolatile store control
    // ------------------------------------------------------------
    logic        supply_meta;
    logic        supply_low;
    logic [19:0] write_cnt;
    logic [9:0]  nvm_waddr;
    logic [7:0]  nvm_wbyte;
    logic        nvm_read_go;
    logic        nvm_write_go;
    logic        nvm_commit;
    logic [9:0]  nvm_mem_addr;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            supply_meta <= 1'b0;
            supply_low  <= 1'b0;
        end else begin
            supply_meta <= low_supply_detector;
            supply_low  <= supply_meta;
        end
    end

    assign req_ready    = !cpu_stall;
    assign cpu_stall    = stall_cnt != 3'd0;
    assign nvm_busy     = write_cnt != 20'd0;
    assign nvm_read_go  = nvm_read_set && !cpu_stall && !nvm_busy;
    assign nvm_write_go = nvm_write_strobe && arm_cnt != 3'd0 &&
                          !cpu_stall && !nvm_busy;
    assign nvm_commit   = write_cnt == 20'd1 && !supply_low;
    assign nvm_mem_addr = nvm_commit ? nvm_waddr : nvm_addr;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arm_cnt <= 3'd0;
        end else if (nvm_write_arm) begin
            arm_cnt <= ARM_WINDOW;
        end else if (arm_cnt != 3'd0) begin
            arm_cnt <= arm_cnt - 3'd1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stall_cnt <= 3'd0;
        end else if (nvm_read_go) begin
            stall_cnt <= NVM_READ_STALL;
        end else if (nvm_write_go) begin
            stall_cnt <= NVM_WRITE_STALL;
        end else if (stall_cnt != 3'd0) begin
            stall_cnt <= stall_cnt - 3'd1;
        end
    end

    // reset is ignored while a write runs; only a low supply abandons it
    always_ff @(posedge clk_sys) begin
        if (nvm_busy) begin
            write_cnt <= supply_low ? 20'd0 : write_cnt - 20'd1;
        end else if (rst) begin
            write_cnt <= 20'd0;
        end else if (nvm_write_go) begin
            write_cnt <= 20'(NVM_WRITE_TIME);
            nvm_waddr <= nvm_addr;
            nvm_wbyte <= nvm_data_in;
        end
    end

    byte_memory #(
        .DEPTH      (NVM_BYTES),
        .ADDR_WIDTH (10)
    ) nvm_mem (
        .clk_sys (clk_sys),
        .we      (nvm_commit),
        .addr    (nvm_mem_addr),
        .wdata   (nvm_wbyte),
        .rdata   (nvm_rdata)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sram_two_cycle: assert property (@(posedge clk_sys) disable iff (rst)
        take && region == region_sram && !req_write |=> resp_valid && region_q == region_sram)
        else $error("sram access did not answer in the second cycle");

    a_nvm_read_stall: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_read_go |=> cpu_stall [*4] ##1 !cpu_stall)
        else $error("nonvolatile read stall is not four cycles");

    a_nvm_write_stall: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_write_go |=> cpu_stall [*2] ##1 !cpu_stall)
        else $error("nonvolatile write stall is not two cycles");

    a_arm_window: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_write_arm ##1 !nvm_write_arm [*5] |-> arm_cnt == 3'd0)
        else $error("write arm outlived four cycles");

    a_bit_range: assert property (@(posedge clk_sys) disable iff (rst)
        io_we && io_wmask != FULL_MASK |-> io_addr <= 8'h1F)
        else $error("bit write outside the low io range");

    a_bit_single: assert property (@(posedge clk_sys) disable iff (rst)
        io_we && io_wmask != FULL_MASK |-> $onehot(io_wmask) && (io_wdata & ~io_wmask) == 8'h00)
        else $error("bit write touches more than one bit");

    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst)
        resp_valid && region_q == region_none |-> resp_rdata == 8'h00 && !reg_sel && !io_sel)
        else $error("unmapped access had an effect");

    a_post_increment: assert property (@(posedge clk_sys) disable iff (rst)
        take && req_mode == post_inc_op |=> ptr_we && ptr_wdata == $past(base) + 16'h0001)
        else $error("post-increment did not update the pointer");

    a_io_offset: assert property (@(posedge clk_sys) disable iff (rst)
        take && req_mode == io_port_op |=> io_sel && io_addr == {2'b00, $past(req_addr[5:0])})
        else $error("port access reached the wrong io location");

endmodule
`default_nettype wire

/* shared/data_space_pkg.sv */
// Operation
// - lowest 32 addresses reach working registers
// - then 64 io, 160 extended io, 2048 sram
// - extended io only via data load/store
// - port read/write use six-bit io address
// - data-space io address is io plus 0x20
// - bit set/clear only on io 0x00-0x1F
// - bit test skips on low io range
// - bit set/clear writes only the addressed bit
// - some status flags clear on writing one
// - sram access completes in two cycles
// - direct addressing reaches whole data space
// - displacement up to 63 on upper pointers
// - registers 26-31 form three pointer pairs
// - pre-decrement before use, post-increment after
// - program counter is fourteen bits wide
// - 1 Kbyte byte-wide nonvolatile store
// - nonvolatile read stalls cpu four cycles
// - nonvolatile write start stalls two cycles
// - self-timed write with busy indication
// - reset does not abort a running write
// - strobe only counts within four cycles of arm
package data_space_pkg;

    // ------------------------------------------------------------
    // data space map
    // ------------------------------------------------------------
    localparam int          ADDR_WIDTH      = 16;
    localparam int          DATA_WIDTH      = 8;
    localparam int          REG_COUNT       = 32;
    localparam int          STD_IO_COUNT    = 64;
    localparam int          EXT_IO_COUNT    = 160;
    localparam int          SRAM_BYTES      = 2048;
    localparam logic [15:0] IO_BASE         = 16'h0020;
    localparam logic [15:0] EXT_IO_BASE     = 16'h0060;
    localparam logic [15:0] SRAM_BASE       = 16'h0100;
    localparam logic [15:0] SRAM_END        = 16'h0900;
    localparam logic [5:0]  BIT_IO_LAST     = 6'h1F;
    localparam logic [5:0]  DISP_MAX        = 6'h3F;
    localparam int          PC_WIDTH        = 14;
    localparam int          NVM_BYTES       = 1024;

    // ------------------------------------------------------------
    // pointer pairs in the register file
    // ------------------------------------------------------------
    localparam logic [4:0]  PTR_X_LOW       = 5'h1A;
    localparam logic [4:0]  PTR_Y_LOW       = 5'h1C;
    localparam logic [4:0]  PTR_Z_LOW       = 5'h1E;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          NVM_WRITE_US    = 3400;
    // divide first so the product stays inside 32 bits
    localparam int          NVM_WRITE_CYCLES = NVM_WRITE_US * (1000000 / CLK_PERIOD_PS);
    localparam logic [2:0]  NVM_READ_STALL  = 3'd4;
    localparam logic [2:0]  NVM_WRITE_STALL = 3'd2;
    localparam logic [2:0]  ARM_WINDOW      = 3'd4;
    localparam logic [7:0]  FULL_MASK       = 8'hFF;

    typedef enum logic [3:0] {
        direct_op,
        io_port_op,
        io_bit_set_op,
        io_bit_clear_op,
        io_bit_skip_if_set_op,
        io_bit_skip_if_clear_op,
        indirect_op,
        indirect_disp_op,
        pre_dec_op,
        post_inc_op
    } access_mode_type;

    typedef enum logic [1:0] {
        ptr_x,
        ptr_y,
        ptr_z
    } ptr_sel_type;

    typedef enum logic [1:0] {
        region_reg,
        region_io,
        region_sram,
        region_none
    } region_type;

endpackage

/* rtl/byte_memory.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_memory #(
    parameter int DEPTH      = 2048,
    parameter int ADDR_WIDTH = 11
) (
    input  wire logic                  clk_sys,
    input  wire logic                  we,
    input  wire logic [ADDR_WIDTH-1:0] addr,
    input  wire logic [7:0]            wdata,
    output logic      [7:0]            rdata
);

    logic [7:0] mem [DEPTH];

    // read returns the old byte on a same-cycle write
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule
`default_nettype wire

/* dv/target_model.sv */
`timescale 1ns/1ps
`default_nettype none
module target_model (
    input  wire logic       clk_sys,
    input  wire logic       reg_sel,
    input  wire logic       reg_we,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       io_sel,
    input  wire logic       io_we,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic [7:0] io_wmask,
    output logic      [7:0] io_rdata
);
    logic [7:0] regs [32];
    logic [7:0] ios  [224]; // no location is reserved here, so every bench write is legal
    // unselected targets show the inverse so a stale value never passes
    assign reg_rdata = reg_sel ? regs[reg_addr] : ~regs[reg_addr];
    assign io_rdata  = io_sel ? ios[io_addr] : ~ios[io_addr];
    always_ff @(posedge clk_sys) begin
        if (reg_sel && reg_we) begin
            regs[reg_addr] <= reg_wdata;
        end
        if (io_sel && io_we) begin
            ios[io_addr] <= (ios[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
        end
    end
endmodule
`default_nettype wire

/* dv/tb_data_space_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_data_space_decoder;
    import data_space_pkg::*;
    localparam int WT = 20;
    logic clk_sys, rst, req_valid, req_ready, req_write, resp_valid, resp_skip, ptr_we;
    logic reg_sel, reg_we, io_sel, io_we, nvm_read_set, nvm_write_arm, nvm_write_strobe;
    logic nvm_busy, cpu_stall, low_supply_detector;
    logic [7:0] req_wdata, resp_rdata, reg_wdata, reg_rdata, io_addr, io_wdata, io_wmask;
    logic [7:0] io_rdata, nvm_data_in, nvm_rdata, q;
    logic [15:0] req_addr, ptr_x_value, ptr_y_value, ptr_z_value, ptr_wdata;
    logic [13:0] pc_next, prog_addr;
    logic [9:0] nvm_addr;
    logic [5:0] req_disp;
    logic [4:0] ptr_low_index, reg_addr;
    logic [2:0] req_bit;
    logic [31:0] seed, r, r2;
    access_mode_type req_mode;
    ptr_sel_type req_ptr;
    logic [7:0] em [int];
    logic [15:0] tbl [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100,
                             16'h08FF, 16'h0900};
    int miscompares, comparisons, sc, bc;

    data_space_decoder #(.NVM_WRITE_TIME(WT)) data_space_decoder_i (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_mode(req_mode), .req_addr(req_addr), .req_ptr(req_ptr),
        .req_disp(req_disp), .req_bit(req_bit), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_skip(resp_skip),
        .ptr_x_value(ptr_x_value), .ptr_y_value(ptr_y_value), .ptr_z_value(ptr_z_value),
        .ptr_we(ptr_we), .ptr_low_index(ptr_low_index), .ptr_wdata(ptr_wdata),
        .reg_sel(reg_sel), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .io_sel(io_sel), .io_we(io_we), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wmask(io_wmask), .io_rdata(io_rdata), .pc_next(pc_next),
        .prog_addr(prog_addr), .nvm_read_set(nvm_read_set), .nvm_write_arm(nvm_write_arm),
        .nvm_write_strobe(nvm_write_strobe), .nvm_addr(nvm_addr), .nvm_data_in(nvm_data_in),
        .nvm_rdata(nvm_rdata), .nvm_busy(nvm_busy), .cpu_stall(cpu_stall),
        .low_supply_detector(low_supply_detector));

    target_model target_model_i (
        .clk_sys(clk_sys), .reg_sel(reg_sel), .reg_we(reg_we), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .io_sel(io_sel), .io_we(io_we),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wmask(io_wmask), .io_rdata(io_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic summarize();
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one data access; pointer modes pass their effective address in a
    task automatic acc(input logic w, input access_mode_type m, input logic [15:0] a,
                       input logic [7:0] d, input logic [2:0] b);
        int ea;
        int n;
        logic [7:0] e;
        logic lo;
        lo = a[5:0] <= BIT_IO_LAST;
        ea = (m == direct_op || m >= indirect_op) ? int'(a) : int'(a[5:0]) + 32;
        e = (ea < 'h900 && em.exists(ea)) ? em[ea] : 8'h00;
        for (n = 0; req_ready !== 1'b1 && n < 20; n++) @(negedge clk_sys);
        if (n == 20) begin
            miscompares++;
            summarize();
        end
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_mode <= m;
        req_addr <= a;
        req_wdata <= d;
        req_bit <= b;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        @(negedge clk_sys);
        check(resp_valid, 1'b1);
        if (m == io_bit_set_op || m == io_bit_clear_op) begin
            check(io_sel, lo);
            if (lo) begin
                check(io_wmask, 8'h01 << b);
                em[ea] = (m == io_bit_set_op) ? (e | (8'h01 << b)) : (e & ~(8'h01 << b));
            end
        end else if (m == io_bit_skip_if_set_op || m == io_bit_skip_if_clear_op) begin
            check(resp_skip, lo && (e[b] == (m == io_bit_skip_if_set_op)));
        end else if (w) begin
            if (ea < 'h900) em[ea] = d;
        end else begin
            check(resp_rdata, e);
        end
    endtask

    // arm, then a read or strobe gap cycles later; counts stall and busy cycles
    task automatic nvm_run(input logic rd, input logic arm, input logic stb, input int gap,
                           input logic rs);
        @(posedge clk_sys);
        nvm_write_arm <= arm;
        @(posedge clk_sys);
        nvm_write_arm <= 1'b0;
        repeat (gap) @(posedge clk_sys);
        nvm_read_set <= rd;
        nvm_write_strobe <= stb;
        @(posedge clk_sys);
        nvm_read_set <= 1'b0;
        nvm_write_strobe <= 1'b0;
        sc = 0;
        bc = 0;
        for (int i = 0; i < WT + 8; i++) begin
            @(negedge clk_sys);
            if (i == 0) q = nvm_rdata;
            sc += int'(cpu_stall);
            bc += int'(nvm_busy);
            @(posedge clk_sys);
            rst <= rs && i >= 5 && i < 7;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'd19;
        {rst, req_valid, req_write, req_bit, req_wdata, req_addr} = '1;
        {nvm_read_set, nvm_write_arm, nvm_write_strobe, low_supply_detector} = '0;
        req_mode = direct_op;
        req_ptr = ptr_x;
        req_disp = 6'h3F;
        {ptr_x_value, ptr_y_value, ptr_z_value} = {16'h0150, 16'h0200, 16'h0300};
        r = rnd();
        pc_next = r[13:0];
        nvm_addr = 10'h3FF;
        nvm_data_in = r[7:0];
        req_valid = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            acc(1'b1, direct_op, tbl[i], r[7:0], 3'd0);
            check(reg_sel, tbl[i] < 16'h0020);
            check(io_sel, tbl[i] >= 16'h0020 && tbl[i] < 16'h0100);
            if (io_sel === 1'b1) check(io_addr, tbl[i] - 16'h0020);
            acc(1'b0, direct_op, tbl[i], 8'h00, 3'd0);
        end
        acc(1'b1, io_port_op, 16'h003F, r[15:8], 3'd0);
        check(io_addr, 8'h3F);
        acc(1'b0, direct_op, 16'h005F, 8'h00, 3'd0);
        acc(1'b1, direct_op, 16'h0025, r[23:16], 3'd0);
        acc(1'b0, io_port_op, 16'h0005, 8'h00, 3'd0);
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            acc(1'b0, access_mode_type'(2 + k % 4), 16'h0005, 8'h00, r[2:0]);
        end
        acc(1'b0, io_bit_set_op, 16'h0020, 8'h00, 3'd1);
        acc(1'b0, io_bit_skip_if_clear_op, 16'h0020, 8'h00, 3'd1);
        acc(1'b0, direct_op, 16'h0025, 8'h00, 3'd0);
        acc(1'b1, post_inc_op, 16'h0150, r[15:8], 3'd0);
        check({ptr_we, ptr_low_index, ptr_wdata}, {1'b1, PTR_X_LOW, 16'h0151});
        acc(1'b0, direct_op, 16'h0150, 8'h00, 3'd0);
        acc(1'b0, indirect_op, 16'h0150, 8'h00, 3'd0);
        @(posedge clk_sys);
        req_ptr <= ptr_y;
        acc(1'b1, direct_op, 16'h01FF, r[7:0], 3'd0);
        acc(1'b0, pre_dec_op, 16'h01FF, 8'h00, 3'd0);
        check({ptr_we, ptr_low_index, ptr_wdata}, {1'b1, PTR_Y_LOW, 16'h01FF});
        @(posedge clk_sys);
        req_ptr <= ptr_z;
        acc(1'b1, indirect_disp_op, 16'h033F, r[31:24], 3'd0);
        acc(1'b0, direct_op, 16'h033F, 8'h00, 3'd0);
        r2 = r;
        nvm_run(1'b0, 1'b1, 1'b1, 3, 1'b0);
        check(sc, 2);
        check(bc, WT);
        nvm_data_in <= r[15:8];
        nvm_run(1'b0, 1'b1, 1'b1, 4, 1'b0);
        check(bc, 0);
        nvm_run(1'b0, 1'b0, 1'b1, 0, 1'b0);
        check(bc, 0);
        nvm_run(1'b1, 1'b0, 1'b0, 0, 1'b0);
        check(q, pc_next[7:0]);
        check(sc, 4);
        check(prog_addr, pc_next);
        nvm_data_in <= r2[23:16];
        nvm_run(1'b0, 1'b1, 1'b1, 0, 1'b1);
        check(bc, WT);
        nvm_run(1'b1, 1'b0, 1'b0, 0, 1'b0);
        check(q, r2[23:16]);
        summarize();
    end
endmodule
`default_nettype wire
